// >>> lio_pkg.sv
// Constants, register map and fault-state type for the line I/O register bank
package lio_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 5;            // 200 MHz pclk
  localparam int FILT_TIME_NS = 1300;          // Glitch qualification time
  localparam int BLANK_T0_NS = 128000;         // 128 us
  localparam int BLANK_T1_NS = 500000;         // 500 us
  localparam int BLANK_T2_NS = 1000000;        // 1 ms
  localparam int BLANK_T3_NS = 5000000;        // 5 ms
  localparam int RETRY_T0_NS = 50000000;       // 50 ms
  localparam int RETRY_T1_NS = 100000000;      // 100 ms
  localparam int RETRY_T2_NS = 200000000;      // 200 ms
  localparam int RETRY_T3_NS = 500000000;      // 500 ms
  // Least times, rounded up to whole cycles
  localparam int FILT_CYC = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_C0 = (BLANK_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_C1 = (BLANK_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_C2 = (BLANK_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_C3 = (BLANK_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_C0 = (RETRY_T0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_C1 = (RETRY_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_C2 = (RETRY_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_C3 = (RETRY_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_CFG_A = 10'h01a;  // line_io_channel_a_cfg_status
  localparam logic [9:0] IDX_CFG_B = 10'h01b;  // line_io_channel_b_cfg_status
  localparam logic [9:0] IDX_DRV = 10'h01c;    // driver_limit_and_retry_cfg
  localparam logic [9:0] IDX_CTRL = 10'h01d;   // Holds the pin override flag
  localparam logic [9:0] IDX_FSTAT = 10'h020;  // Sticky and live fault flags
  localparam logic [9:0] IDX_FMASK = 10'h021;  // Fault interrupt mask

  // ==========================================================
  // Field positions
  localparam int CFG_AUX_LEVEL = 7;
  localparam int CFG_LINE_LEVEL = 6;
  localparam int CFG_SW_EN = 5;
  localparam int CFG_SW_DATA = 4;
  localparam int CFG_FILT_ON = 3;
  localparam int CFG_THR_TYPE = 2;
  localparam int CFG_SRC_ON = 1;
  localparam int CFG_SINK_ON = 0;
  localparam int DRV_LIM_HI = 7;
  localparam int DRV_LIM_LO = 6;
  localparam int DRV_LIM_OFF = 5;
  localparam int DRV_BLANK_HI = 4;
  localparam int DRV_BLANK_LO = 3;
  localparam int DRV_RETRY_HI = 2;
  localparam int DRV_RETRY_LO = 1;
  localparam int DRV_RETRY_EN = 0;
  localparam int CTRL_OVERRIDE = 6;
  localparam int FSTAT_LIVE_LO = 4;
  localparam int NUM_CH = 2;

  // ==========================================================
  // Reset values
  localparam logic [5:0] CFG_RST = 6'h00;
  localparam logic [7:0] DRV_RST = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // Per-channel driver fault sequence
  typedef enum logic [2:0] {lio_run, lio_blank, lio_off, lio_recheck, lio_latch} lio_fault_e;

endpackage

// >>> lio_line_io_regs.sv
// Line I/O configuration registers, aux input filter and driver fault sequencer
// Function
// RQ1: Report aux input level read-only
// RQ2: Report line level read-only
// RQ3: Override makes register enable act as pin
// RQ4: Override makes register data drive line
// RQ5: Filter bit inserts 1.3us glitch filter
// RQ6: Threshold bit selects type 2/3 or 1
// RQ7: Source bit switches 2mA current source
// RQ8: Sink bit switches 2mA current sink
// RQ9: Limit field picks shared driver current limit
// RQ10: Limit-off bit disables current limiting
// RQ11: Fault flagged after selected blanking time
// RQ12: Retry field selects driver off time
// RQ13: Faulted driver off for retry time
// RQ14: Recheck after one blanking; refault if persists
// RQ15: Fault gone at recheck clears status
// RQ16: Software picks long blanking for big loads
// RQ17: Override flag hands line control to registers
// RQ18: No retry: driver latched off until reconfig
// RQ19: Per-channel counters on internal clock
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module lio_line_io_regs
  import lio_pkg::*;
#(
  parameter int BLANK_CYC0 = BLANK_C0,
  parameter int BLANK_CYC1 = BLANK_C1,
  parameter int BLANK_CYC2 = BLANK_C2,
  parameter int BLANK_CYC3 = BLANK_C3,
  parameter int RETRY_CYC0 = RETRY_C0,
  parameter int RETRY_CYC1 = RETRY_C1,
  parameter int RETRY_CYC2 = RETRY_C2,
  parameter int RETRY_CYC3 = RETRY_C3,
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic aux_input_pin_a,
  input wire logic aux_input_pin_b,
  input wire logic line_pin_a,
  input wire logic line_pin_b,
  input wire logic drive_data_pin_a,
  input wire logic drive_data_pin_b,
  input wire logic drive_enable_pin_a,
  input wire logic drive_enable_pin_b,
  input wire logic driver_overload_a,
  input wire logic driver_overload_b,
  output logic line_drive_data_a,
  output logic line_drive_data_b,
  output logic line_drive_enable_a,
  output logic line_drive_enable_b,
  output logic aux_threshold_type_a,
  output logic aux_threshold_type_b,
  output logic aux_source_on_a,
  output logic aux_source_on_b,
  output logic aux_sink_on_a,
  output logic aux_sink_on_b,
  output logic [1:0] driver_limit_level,
  output logic driver_limit_off,
  output logic [1:0] driver_fault,
  output logic irq
);

  // ==========
  // Register state
  logic [5:0] cfg_r [NUM_CH];      // Writable low bits of each channel register
  logic [7:0] drv_r;               // Shared driver configuration
  logic override_r;                // Pin control handed to registers
  logic [1:0] sticky_r;            // Fault events, write one to clear
  logic [1:0] mask_r;              // Interrupt enables, same layout
  logic [1:0] aux_lvl_r;           // Aux level after optional filter
  logic [1:0] line_lvl_r;          // Sampled line level
  logic [1:0] fault_r;             // Live fault flag per channel
  logic [1:0] fault_evt;           // One-cycle fault detection pulse
  logic [1:0] drv_off;             // Driver held off by the sequencer
  logic [1:0] reconfig;            // Write that releases a latched driver
  logic irq_r, pready_r, pslverr_r; // Output flops
  logic [31:0] prdata_r, rd_data; // Read data, registered and live
  logic [9:0] idx; // Register index from the byte address
  logic hit, acc_first, acc_done, wr; // Decode terms
  // Per-channel pin gathering
  logic [1:0] aux_pin, line_pin, dd_pin, de_pin, ovl;
  logic [1:0] out_data_r, out_en_r; // Transmitter flops
  assign aux_pin = {aux_input_pin_b, aux_input_pin_a};
  assign line_pin = {line_pin_b, line_pin_a};
  assign dd_pin = {drive_data_pin_b, drive_data_pin_a};
  assign de_pin = {drive_enable_pin_b, drive_enable_pin_a};
  assign ovl = {driver_overload_b, driver_overload_a};

  // ==========
  // APB decode
  assign idx = paddr[11:2];
  assign acc_first = psel & penable & ~pready_r;
  assign acc_done = psel & penable & pready_r;
  assign wr = acc_done & pwrite & hit & pstrb[0];
  // Address match; anything else answers with an error
  assign hit = idx inside {IDX_CFG_A, IDX_CFG_B, IDX_DRV, IDX_CTRL, IDX_FSTAT, IDX_FMASK};
  // Read mux; upper bits read as zero
  always_comb
  begin
    rd_data = RD_ZERO;
    case (idx)
      IDX_CFG_A: rd_data[7:0] = {aux_lvl_r[0], line_lvl_r[0], cfg_r[0]}; // RQ1 RQ2
      IDX_CFG_B: rd_data[7:0] = {aux_lvl_r[1], line_lvl_r[1], cfg_r[1]}; // RQ1 RQ2
      IDX_DRV: rd_data[7:0] = drv_r;
      IDX_CTRL: rd_data[CTRL_OVERRIDE] = override_r;
      IDX_FSTAT: rd_data[5:0] = {fault_r, 2'b00, sticky_r};
      IDX_FMASK: rd_data[1:0] = mask_r;
      default: rd_data = RD_ZERO;
    endcase
  end

  // One wait state: data is captured in the first access cycle, ready follows
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= RD_ZERO;
    end
    else if (clk_en)
    begin
      if (acc_first)
      begin
        pready_r <= 1'b1;
        pslverr_r <= ~hit;
        prdata_r <= hit ? rd_data : RD_ZERO;
      end
      else
      begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
      end
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;

  // ==========
  // Configuration writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_r[0] <= CFG_RST;
      cfg_r[1] <= CFG_RST;
      drv_r <= DRV_RST;
      override_r <= 1'b0;
      mask_r <= 2'b00;
    end
    else if (clk_en && wr)
    begin
      case (idx)
        IDX_CFG_A: cfg_r[0] <= pwdata[5:0];
        IDX_CFG_B: cfg_r[1] <= pwdata[5:0];
        IDX_DRV: drv_r <= pwdata[7:0];
        IDX_CTRL: override_r <= pwdata[CTRL_OVERRIDE]; // RQ17
        IDX_FMASK: mask_r <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Reconfiguration releases a latched-off driver
  assign reconfig[0] = wr & ((idx == IDX_DRV) | (idx == IDX_CFG_A)); // RQ18
  assign reconfig[1] = wr & ((idx == IDX_DRV) | (idx == IDX_CFG_B)); // RQ18

  // ==========
  // Fault flags and interrupt
  // A new event in the clearing cycle wins, so no fault is lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sticky_r <= 2'b00;
      irq_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr && idx == IDX_FSTAT)
        sticky_r <= (sticky_r & ~pwdata[1:0]) | fault_evt;
      else
        sticky_r <= sticky_r | fault_evt;
      irq_r <= |((sticky_r | fault_evt) & mask_r);
    end
  end

  assign irq = irq_r;
  assign driver_fault = fault_r;

  // Shared limit settings go straight out of the register
  assign driver_limit_level = drv_r[DRV_LIM_HI:DRV_LIM_LO]; // RQ9
  assign driver_limit_off = drv_r[DRV_LIM_OFF]; // RQ10

  // Blanking count from its select code
  function automatic logic [31:0] blank_len(input logic [1:0] sel);
    case (sel)
      2'h0: blank_len = 32'(BLANK_CYC0);
      2'h1: blank_len = 32'(BLANK_CYC1);
      2'h2: blank_len = 32'(BLANK_CYC2);
      default: blank_len = 32'(BLANK_CYC3);
    endcase
  endfunction

  // Off-time count from its select code
  function automatic logic [31:0] retry_len(input logic [1:0] sel);
    case (sel)
      2'h0: retry_len = 32'(RETRY_CYC0);
      2'h1: retry_len = 32'(RETRY_CYC1);
      2'h2: retry_len = 32'(RETRY_CYC2);
      default: retry_len = 32'(RETRY_CYC3);
    endcase
  endfunction

  // ==========
  // Per-channel logic
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ch
    logic [15:0] filt_cnt_r;       // Filter qualification counter
    logic [31:0] cnt_r;            // Blanking and off-time counter
    logic [31:0] blank_cyc, retry_cyc; // Lengths for the current codes
    lio_fault_e st_r;
    assign blank_cyc = blank_len(drv_r[DRV_BLANK_HI:DRV_BLANK_LO]); // RQ11
    assign retry_cyc = retry_len(drv_r[DRV_RETRY_HI:DRV_RETRY_LO]); // RQ12

    // Aux input: a change must hold the whole qualification time when filtered
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        aux_lvl_r[ch] <= 1'b0;
        filt_cnt_r <= 16'h0000;
      end
      else if (clk_en)
      begin
        if (!cfg_r[ch][CFG_FILT_ON])
        begin
          aux_lvl_r[ch] <= aux_pin[ch]; // RQ5 RQ1
          filt_cnt_r <= 16'h0000;
        end
        else if (aux_pin[ch] == aux_lvl_r[ch])
          filt_cnt_r <= 16'h0000;
        else if (filt_cnt_r >= 16'(FILT_CYC - 1))
        begin
          aux_lvl_r[ch] <= aux_pin[ch]; // RQ5
          filt_cnt_r <= 16'h0000;
        end
        else
          filt_cnt_r <= filt_cnt_r + 16'h0001;
      end
    end

    // Line level sampled for status
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        line_lvl_r[ch] <= 1'b0;
      else if (clk_en)
        line_lvl_r[ch] <= line_pin[ch]; // RQ2
    end

    // Transmitter source select; a held-off driver is never enabled
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        out_data_r[ch] <= 1'b0;
        out_en_r[ch] <= 1'b0;
      end
      else if (clk_en)
      begin
        if (override_r)
        begin
          out_data_r[ch] <= cfg_r[ch][CFG_SW_DATA]; // RQ4 RQ17
          out_en_r[ch] <= cfg_r[ch][CFG_SW_EN] & ~drv_off[ch]; // RQ3 RQ17
        end
        else
        begin
          out_data_r[ch] <= dd_pin[ch]; // RQ4
          out_en_r[ch] <= de_pin[ch] & ~drv_off[ch]; // RQ3
        end
      end
    end

    // Fault sequencer; counter is private to this channel
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        st_r <= lio_run;
        cnt_r <= 32'h0000_0000;
        fault_r[ch] <= 1'b0;
      end
      else if (clk_en)
      begin
        case (st_r)
          // Normal drive; an overload starts blanking
          lio_run:
          begin
            cnt_r <= 32'h0000_0000;
            if (ovl[ch])
              st_r <= lio_blank;
          end
          // Short overloads such as inrush are tolerated
          lio_blank:
          begin
            if (!ovl[ch])
              st_r <= lio_run;
            else if (cnt_r >= blank_cyc - 32'h1)
            begin
              fault_r[ch] <= 1'b1; // RQ11
              cnt_r <= 32'h0000_0000;
              st_r <= drv_r[DRV_RETRY_EN] ? lio_off : lio_latch; // RQ13 RQ18
            end
            else
              cnt_r <= cnt_r + 32'h1; // RQ19
          end
          // Driver off for the retry time
          lio_off:
          begin
            if (cnt_r >= retry_cyc - 32'h1)
            begin
              cnt_r <= 32'h0000_0000;
              st_r <= lio_recheck; // RQ13
            end
            else
              cnt_r <= cnt_r + 32'h1; // RQ19
          end
          // Re-enabled; judge the fault after one blanking time
          lio_recheck:
          begin
            if (cnt_r >= blank_cyc - 32'h1)
            begin
              cnt_r <= 32'h0000_0000;
              if (ovl[ch])
                st_r <= lio_off; // RQ14
              else
              begin
                fault_r[ch] <= 1'b0; // RQ15
                st_r <= lio_run; // RQ15
              end
            end
            else
              cnt_r <= cnt_r + 32'h1; // RQ19
          end
          // Held off until software touches the configuration
          lio_latch:
          begin
            cnt_r <= 32'h0000_0000;
            if (reconfig[ch])
            begin
              fault_r[ch] <= 1'b0; // RQ18
              st_r <= lio_run;
            end
          end
          default:
          begin
            st_r <= lio_run;
            cnt_r <= 32'h0000_0000;
          end
        endcase
      end
    end

    // Event fires only on the first detection, not on refaults
    assign fault_evt[ch] = clk_en & (st_r == lio_blank) & ovl[ch] & (cnt_r >= blank_cyc - 32'h1);
    assign drv_off[ch] = (st_r == lio_off) | (st_r == lio_latch); // RQ13
  end

  // ==========
  // Output wiring, all from flip-flops
  assign {line_drive_data_b, line_drive_data_a} = out_data_r;
  assign {line_drive_enable_b, line_drive_enable_a} = out_en_r;
  assign {aux_threshold_type_b, aux_threshold_type_a} = {cfg_r[1][CFG_THR_TYPE], cfg_r[0][CFG_THR_TYPE]}; // RQ6
  assign {aux_source_on_b, aux_source_on_a} = {cfg_r[1][CFG_SRC_ON], cfg_r[0][CFG_SRC_ON]}; // RQ7
  assign {aux_sink_on_b, aux_sink_on_a} = {cfg_r[1][CFG_SINK_ON], cfg_r[0][CFG_SINK_ON]}; // RQ8

endmodule

// >>> lio_line_io_chk.sv
// Port-level assertions for the line I/O register bank
`timescale 1ns/1ps
module lio_line_io_chk
  import lio_pkg::*;
#(
  parameter int BLANK_CYC0 = 8,
  parameter int BLANK_CYC1 = 12,
  parameter int BLANK_CYC2 = 16,
  parameter int BLANK_CYC3 = 20,
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic drive_data_pin_a,
  input wire logic drive_enable_pin_a,
  input wire logic driver_overload_a,
  input wire logic line_drive_data_a,
  input wire logic line_drive_enable_a,
  input wire logic [1:0] driver_fault,
  input wire logic irq
);
  // ==========
  // Shadows of override flag and driver setup
  logic ovr_r;
  logic [7:0] drv_r;
  int ovl_cnt_r; // Consecutive overload cycles, saturating
  int blk; // Blanking length now selected
  logic wr_done;
  logic any_flt;
  assign wr_done = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
  assign any_flt = |driver_fault;
  assign blk = (drv_r[4:3] == 2'h0) ? BLANK_CYC0 : (drv_r[4:3] == 2'h1) ? BLANK_CYC1 :
    (drv_r[4:3] == 2'h2) ? BLANK_CYC2 : BLANK_CYC3;
  // Follow completed writes, as the design applies them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ovr_r <= 1'b0;
      drv_r <= 8'h00;
    end
    else if (wr_done && paddr == {IDX_CTRL, 2'h0})
      ovr_r <= pwdata[CTRL_OVERRIDE];
    else if (wr_done && paddr == {IDX_DRV, 2'h0})
      drv_r <= pwdata[7:0];
  end
  // Saturation keeps the counter bounded on long shorts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ovl_cnt_r <= 0;
    else if (!driver_overload_a)
      ovl_cnt_r <= 0;
    else if (ovl_cnt_r < 1000)
      ovl_cnt_r <= ovl_cnt_r + 1;
  end
  // ==========
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wait_state;
    psel && penable && !pready;
  endsequence
  sequence s_held_off;
    !line_drive_enable_a [*8];
  endsequence
  a_ready_one_wait: assert property (s_wait_state |=> pready)
    else $error("pready missing after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_no_data: assert property (pslverr |-> pready && prdata == RD_ZERO)
    else $error("error response with data");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_pin_data: assert property ($past(presetn) && !$past(ovr_r) |-> line_drive_data_a == $past(drive_data_pin_a))
    else $error("line data does not follow pin");
  a_pin_enable_follow: assert property ($past(presetn) && !$past(ovr_r) && !$past(driver_fault[0]) &&
    !driver_fault[0] |-> line_drive_enable_a == $past(drive_enable_pin_a))
    else $error("line enable does not follow pin");
  a_blank_min: assert property ($rose(driver_fault[0]) |-> ovl_cnt_r >= blk)
    else $error("fault flagged before blanking time");
  a_blank_max: assert property (ovl_cnt_r == blk + 3 |-> driver_fault[0])
    else $error("fault not flagged after blanking time");
  a_fault_off: assert property ($rose(driver_fault[0]) |=> s_held_off)
    else $error("driver not held off after fault");
  a_irq_cause: assert property ($rose(irq) |-> any_flt || $past(wr_done, 2))
    else $error("interrupt without cause");
endmodule

// >>> lio_field_model.sv
// Field-side model: sensor levels, line wiring and load shorts
`timescale 1ns/1ps
module lio_field_model
(
  input wire logic line_drive_data_a,
  input wire logic line_drive_enable_a,
  input wire logic line_drive_data_b,
  input wire logic line_drive_enable_b,
  input wire logic short_a,
  input wire logic short_b,
  input wire logic sense_a,
  input wire logic sense_b,
  output logic line_pin_a,
  output logic line_pin_b,
  output logic driver_overload_a,
  output logic driver_overload_b
);
  // An enabled driver owns the line; a released line shows the sensor
  assign line_pin_a = line_drive_enable_a ? line_drive_data_a : sense_a;
  assign line_pin_b = line_drive_enable_b ? line_drive_data_b : sense_b;
  // A short overloads only while driving, so the off time removes it
  assign driver_overload_a = short_a && line_drive_enable_a;
  assign driver_overload_b = short_b && line_drive_enable_b;
endmodule

// >>> tb_top.sv
// Self-checking bench for the line I/O register bank
`timescale 1ns/1ps
module tb_top;
  import lio_pkg::*;
  // ==========================================
  // Signals named as the design ports
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq, driver_limit_off;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic [3:0] pstrb;
  logic aux_input_pin_a, aux_input_pin_b, line_pin_a, line_pin_b, err;
  logic drive_data_pin_a, drive_data_pin_b, drive_enable_pin_a, drive_enable_pin_b;
  logic driver_overload_a, driver_overload_b, line_drive_data_a, line_drive_data_b;
  logic line_drive_enable_a, line_drive_enable_b, aux_threshold_type_a, aux_threshold_type_b;
  logic aux_source_on_a, aux_source_on_b, aux_sink_on_a, aux_sink_on_b;
  logic [1:0] driver_limit_level, driver_fault;
  logic short_a, short_b, sense_a, sense_b; // Field commands
  int failures, comparisons, cyc, t, i;
  localparam int BLK [4] = '{8, 12, 16, 20}; // Shortened blanking counts
  localparam int RTY [4] = '{30, 40, 50, 60}; // Shortened retry counts
  lio_line_io_regs #(.BLANK_CYC0(8), .BLANK_CYC1(12), .BLANK_CYC2(16), .BLANK_CYC3(20),
    .RETRY_CYC0(30), .RETRY_CYC1(40), .RETRY_CYC2(50), .RETRY_CYC3(60)) dut_u (.*);
  lio_field_model fld_u (.*);
  // ==========
  // Clock and hang guard
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      final_report();
    end
  end
  // ==========================================
  // Helpers
  function automatic logic [31:0] exp_cfg(logic aux, logic line, logic [7:0] v);
    return {24'h0, aux, line, v[5:0]};
  endfunction
  function automatic logic exp_drive(logic ovr, logic sw, logic pin);
    return ovr ? sw : pin;
  endfunction
  function automatic logic [31:0] in_range(int v, int lo, int hi);
    return {31'h0, v >= lo && v <= hi};
  endfunction
  function automatic logic pick(int w);
    case (w)
      0: return driver_fault[0];
      1: return line_drive_enable_a;
      default: return driver_fault[1];
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for a level; t returns the cycles spent
  task automatic wait_for(input int w, input logic lvl);
    t = 0;
    while (pick(w) !== lvl && t < 400)
    begin
      @(posedge pclk);
      t++;
    end
  endtask
  // One APB transfer; the request holds until pready is seen
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd, input logic [3:0] st);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    pstrb <= st;
    @(posedge pclk);
    penable <= psel;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic final_report();
    $display("Comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {aux_input_pin_a, aux_input_pin_b, drive_data_pin_a, drive_data_pin_b} = '0;
    {drive_enable_pin_a, drive_enable_pin_b, short_a, short_b, sense_a, sense_b} = '0;
    clk_en = 1'b1;
    r = $urandom(32'h302d);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 3; i++)
    begin
      apb(1'b0, IDX_CFG_A + 10'(i), 32'h0, 4'hf);
      chk(rd, 32'h0);
    end
    apb(1'b0, 10'h3ff, 32'h0, 4'hf);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("Test reset done");
    repeat (8)
    begin
      r = $urandom;
      r[3] = 1'b0; // Filter off so levels show in one cycle
      r[19] = 1'b0;
      aux_input_pin_a <= r[8];
      sense_a <= r[9];
      aux_input_pin_b <= r[10];
      sense_b <= r[11];
      apb(1'b1, IDX_CFG_A, {24'h0, r[7:0]}, 4'h1);
      apb(1'b1, IDX_CFG_B, {24'h0, r[23:16]}, 4'h1);
      apb(1'b0, IDX_CFG_A, 32'h0, 4'hf);
      chk(rd, exp_cfg(r[8], r[9], r[7:0]));
      apb(1'b0, IDX_CFG_B, 32'h0, 4'hf);
      chk(rd, exp_cfg(r[10], r[11], r[23:16]));
      chk({29'h0, aux_threshold_type_a, aux_source_on_a, aux_sink_on_a}, {29'h0, r[2:0]});
      chk({29'h0, aux_threshold_type_b, aux_source_on_b, aux_sink_on_b}, {29'h0, r[18:16]});
    end
    apb(1'b1, IDX_CFG_A, 32'h3f, 4'h0);
    apb(1'b0, IDX_CFG_A, 32'h0, 4'hf);
    chk(rd, exp_cfg(r[8], r[9], r[7:0]));
    $display("Test config done");
    for (i = 0; i < 8; i++)
    begin
      apb(1'b1, IDX_DRV, 32'(i) << 5, 4'hf);
      chk({29'h0, driver_limit_level, driver_limit_off}, 32'(i));
      apb(1'b0, IDX_DRV, 32'h0, 4'hf);
      chk(rd, 32'(i) << 5);
    end
    $display("Test limits done");
    repeat (8)
    begin
      r = $urandom;
      drive_data_pin_a <= r[0];
      drive_enable_pin_a <= r[1];
      drive_data_pin_b <= r[2];
      drive_enable_pin_b <= r[3];
      apb(1'b1, IDX_CTRL, {25'h0, r[6], 6'h0}, 4'h1);
      apb(1'b1, IDX_CFG_A, {26'h0, r[5:4], 4'h0}, 4'h1);
      apb(1'b1, IDX_CFG_B, {26'h0, r[5:4], 4'h0}, 4'h1);
      @(posedge pclk);
      chk({30'h0, line_drive_data_b, line_drive_data_a},
        {30'h0, exp_drive(r[6], r[4], r[2]), exp_drive(r[6], r[4], r[0])});
      chk({30'h0, line_drive_enable_b, line_drive_enable_a},
        {30'h0, exp_drive(r[6], r[5], r[3]), exp_drive(r[6], r[5], r[1])});
    end
    apb(1'b1, IDX_CTRL, 32'h0, 4'h1);
    $display("Test override done");
    aux_input_pin_a <= 1'b0;
    apb(1'b1, IDX_CFG_A, 32'h08, 4'h1);
    repeat (FILT_CYC + 4) @(posedge pclk);
    aux_input_pin_a <= 1'b1;
    repeat (FILT_CYC - 10) @(posedge pclk);
    aux_input_pin_a <= 1'b0; // One-cycle bounce restarts qualification
    @(posedge pclk);
    aux_input_pin_a <= 1'b1;
    repeat (FILT_CYC - 10) @(posedge pclk);
    apb(1'b0, IDX_CFG_A, 32'h0, 4'hf);
    chk({31'h0, rd[7]}, 32'h0);
    repeat (20) @(posedge pclk);
    apb(1'b0, IDX_CFG_A, 32'h0, 4'hf);
    chk({31'h0, rd[7]}, 32'h1);
    $display("Test filter done");
    apb(1'b1, IDX_CFG_A, 32'h0, 4'h1);
    apb(1'b1, IDX_FMASK, 32'h3, 4'h1);
    drive_enable_pin_a <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, IDX_DRV, 32'(i * 10 + 1), 4'h1);
      short_a <= 1'b1;
      wait_for(0, 1'b1);
      chk(in_range(t, BLK[i], BLK[i] + 3), 32'h1);
      wait_for(1, 1'b0);
      wait_for(1, 1'b1);
      chk(in_range(t, RTY[i] - 2, RTY[i] + 4), 32'h1);
      wait_for(1, 1'b0);
      chk(in_range(t, BLK[i] - 2, BLK[i] + 3), 32'h1);
      chk({31'h0, driver_fault[0]}, 32'h1);
      short_a <= 1'b0;
      wait_for(0, 1'b0);
      chk(in_range(t, RTY[i], RTY[i] + BLK[i] + 8), 32'h1);
    end
    apb(1'b0, IDX_FSTAT, 32'h0, 4'hf);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, IDX_FSTAT, 32'h1, 4'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("Test retry done");
    apb(1'b1, IDX_FMASK, 32'h0, 4'h1);
    apb(1'b1, IDX_DRV, 32'h08, 4'h1); // Blank code 1, retry off
    drive_enable_pin_b <= 1'b1;
    short_b <= 1'b1;
    wait_for(2, 1'b1);
    chk(in_range(t, BLK[1], BLK[1] + 3), 32'h1);
    repeat (RTY[3] + 40) @(posedge pclk);
    chk({30'h0, driver_fault}, 32'h2);
    chk({30'h0, line_drive_enable_b, irq}, 32'h0);
    apb(1'b0, IDX_FSTAT, 32'h0, 4'hf);
    chk(rd, 32'h22);
    apb(1'b1, IDX_FMASK, 32'h2, 4'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    short_b <= 1'b0;
    apb(1'b1, IDX_DRV, 32'h08, 4'h1);
    repeat (2) @(posedge pclk);
    chk({30'h0, driver_fault[1], line_drive_enable_b}, 32'h1);
    apb(1'b1, IDX_FSTAT, 32'h2, 4'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("Test latch done");
    final_report();
  end
endmodule
bind lio_line_io_regs lio_line_io_chk #(.BLANK_CYC0(BLANK_CYC0), .BLANK_CYC1(BLANK_CYC1),
  .BLANK_CYC2(BLANK_CYC2), .BLANK_CYC3(BLANK_CYC3), .ADDR_W(ADDR_W)) chk_u (.*);
